// File: verilog/lamp_consts.svh
`ifndef LAMP_CONSTS_SVH
`define LAMP_CONSTS_SVH

//**************************************************************
// Register map
//**************************************************************
`define LAMP_SEL_OFFSET     12'h000
`define LAMP_EVT_OFFSET     12'h004

//**************************************************************
// Selection register fields
//**************************************************************
`define LAMP_BIT_COL        0
`define LAMP_BIT_JAB        1
`define LAMP_BIT_RX         2
`define LAMP_BIT_POL        3
`define LAMP_BIT_TX         4
`define LAMP_BIT_STRETCH    7
`define LAMP_BIT_LIVE       15
`define LAMP_NUM_SRC        5
`define LAMP_SEL_RESET      16'h0084
`define LAMP_SEL_WMASK      16'h009f

//**************************************************************
// Event status register fields
//**************************************************************
`define LAMP_EVT_BIT_LIT    8

//**************************************************************
// Timing
//**************************************************************
`define LAMP_CLK_FREQ_KHZ   25000
`define LAMP_STRETCH_MS     100
`define LAMP_STRETCH_CYCLES (`LAMP_STRETCH_MS * `LAMP_CLK_FREQ_KHZ)

`endif

// File: verilog/lamp_pkg.sv
package lamp_pkg;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_FOLLOW = 3'b010,
    ST_HOLD   = 3'b100
  } stretch_state_t;

  typedef logic [4:0] src_vec_t;

endpackage

// File: verilog/lamp_stretch_if.sv
`timescale 1ns/10ps

interface lamp_stretch_if;
  logic live;
  logic stretch_en;
  logic lit;

  modport ctrl (
    output live,
    output stretch_en,
    input  lit
  );

  modport stretcher (
    input  live,
    input  stretch_en,
    output lit
  );
endinterface

// File: verilog/lamp_stretcher.sv
`timescale 1ns/10ps
`include "lamp_consts.svh"

module lamp_stretcher #(
  parameter int STRETCH_CYCLES = `LAMP_STRETCH_CYCLES
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_b,
  input  wire logic               i_clk_en,
  lamp_stretch_if.stretcher       lsi
);

  localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(STRETCH_CYCLES - 1);

  lamp_pkg::stretch_state_t state_r;
  lamp_pkg::stretch_state_t state_nxt;
  logic [CNT_W-1:0]         cnt_r;
  logic [CNT_W-1:0]         cnt_nxt;
  logic                     lit_r;
  logic                     lit_nxt;

  //**************************************************************
  // Next state
  //**************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!lsi.stretch_en) begin
      state_nxt = lamp_pkg::ST_OFF;
      cnt_nxt   = '0;
    end else if (lsi.live) begin
      state_nxt = lamp_pkg::ST_FOLLOW;
      cnt_nxt   = RELOAD;
    end else begin
      unique case (state_r)
        lamp_pkg::ST_OFF: begin
          state_nxt = lamp_pkg::ST_OFF;
        end
        lamp_pkg::ST_FOLLOW: begin
          state_nxt = lamp_pkg::ST_HOLD;
        end
        lamp_pkg::ST_HOLD: begin
          if (cnt_r == '0) begin
            state_nxt = lamp_pkg::ST_OFF;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        default: begin
          state_nxt = lamp_pkg::ST_OFF;
        end
      endcase
    end
    lit_nxt = lsi.stretch_en ? (state_nxt != lamp_pkg::ST_OFF) : lsi.live;
  end

  //**************************************************************
  // State registers
  //**************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_r <= lamp_pkg::ST_OFF;
      cnt_r   <= '0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      lit_r <= 1'b0;
    end else if (i_clk_en) begin
      lit_r <= lit_nxt;
    end
  end

  assign lsi.lit = lit_r;

endmodule

// File: verilog/status_lamp_select.sv
//**************************************************************
//**************************************************************
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "lamp_consts.svh"

module status_lamp_select #(
  parameter int STRETCH_CYCLES = `LAMP_STRETCH_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_tx_active,
  input  wire logic        i_rx_active,
  input  wire logic        i_rx_polarity_ok,
  input  wire logic        i_jabber,
  input  wire logic        i_collision,
  output logic             o_second_status_lamp_pin_b
);

  //**************************************************************
  // Declarations
  //**************************************************************
  lamp_pkg::src_vec_t src_evt;
  lamp_pkg::src_vec_t src_gated;
  logic [15:0]        lamp_sel_r;
  logic [15:0]        lamp_sel_nxt;
  logic               lamp_live_state;
  logic               stretch_enable;
  logic               apb_setup;
  logic               apb_access;
  logic               hit_sel;
  logic               hit_evt;
  logic               addr_ok;
  logic               sel_wr;
  logic [15:0]        sel_rd_val;
  logic [15:0]        evt_rd_val;
  logic [31:0]        rd_mux;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic               lamp_pin_b_r;

  lamp_stretch_if lsi ();

  //**************************************************************
  // Event sources
  //**************************************************************
  always_comb begin
    src_evt                   = '0;
    src_evt[`LAMP_BIT_COL]    = i_collision;
    src_evt[`LAMP_BIT_JAB]    = i_jabber;
    src_evt[`LAMP_BIT_RX]     = i_rx_active;
    src_evt[`LAMP_BIT_POL]    = i_rx_polarity_ok;
    src_evt[`LAMP_BIT_TX]     = i_tx_active;
  end

  //**************************************************************
  // Source gating
  //**************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LAMP_NUM_SRC; gi = gi + 1) begin : g_src
      assign src_gated[gi] = lamp_sel_r[gi] & src_evt[gi];
    end
  endgenerate

  //**************************************************************
  // Combined live state
  //**************************************************************
  assign lamp_live_state = |src_gated;

  assign stretch_enable = lamp_sel_r[`LAMP_BIT_STRETCH];

  //**************************************************************
  // Bus decode
  //**************************************************************
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;

  assign hit_sel = (i_paddr == `LAMP_SEL_OFFSET);
  assign hit_evt = (i_paddr == `LAMP_EVT_OFFSET);
  assign addr_ok = hit_sel | hit_evt;

  assign o_pready = i_clk_en;

  assign sel_wr = apb_access & i_pwrite & hit_sel & i_pstrb[0];

  //**************************************************************
  // Selection register
  //**************************************************************
  always_comb begin
    lamp_sel_nxt = lamp_sel_r;
    if (sel_wr) begin
      lamp_sel_nxt = i_pwdata[15:0] & `LAMP_SEL_WMASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      lamp_sel_r <= `LAMP_SEL_RESET;
    end else if (i_clk_en) begin
      lamp_sel_r <= lamp_sel_nxt;
    end
  end

  //**************************************************************
  // Read values
  //**************************************************************
  always_comb begin
    sel_rd_val                 = lamp_sel_r & `LAMP_SEL_WMASK;
    sel_rd_val[`LAMP_BIT_LIVE] = lamp_live_state;
  end

  always_comb begin
    evt_rd_val                      = 16'h0000;
    evt_rd_val[`LAMP_NUM_SRC-1:0]   = src_evt;
    evt_rd_val[`LAMP_EVT_BIT_LIT]   = lsi.lit;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_sel) begin
      rd_mux = {16'h0000, sel_rd_val};
    end else if (hit_evt) begin
      rd_mux = {16'h0000, evt_rd_val};
    end
  end

  //**************************************************************
  // Read data capture
  //**************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (apb_setup) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign o_prdata = prdata_r;

  //**************************************************************
  // Error response
  //**************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pslverr_r <= 1'b0;
    end else if (i_clk_en) begin
      if (apb_setup) begin
        pslverr_r <= ~addr_ok;
      end
    end
  end

  assign o_pslverr = pslverr_r & apb_access;

  //**************************************************************
  // Pulse stretcher
  //**************************************************************
  assign lsi.live       = lamp_live_state;
  assign lsi.stretch_en = stretch_enable;

  lamp_stretcher #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .lsi       (lsi.stretcher)
  );

  //**************************************************************
  // Lamp pin
  //**************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      lamp_pin_b_r <= 1'b1;
    end else if (i_clk_en) begin
      lamp_pin_b_r <= ~lsi.lit;
    end
  end

  assign o_second_status_lamp_pin_b = lamp_pin_b_r;

endmodule

// File: tb/status_lamp_select_checker.sv
`timescale 1ns/10ps
//****
// Port checks
//****
module lamp_sel_checker #(
  parameter int STRETCH_CYCLES = 8
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  input wire logic        i_clk_en,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_tx_active,
  input wire logic        i_rx_active,
  input wire logic        i_rx_polarity_ok,
  input wire logic        i_jabber,
  input wire logic        i_collision,
  input wire logic        o_second_status_lamp_pin_b
);
  logic [31:0] idle_cnt_r;
  logic        any_ev;
  logic        acc;
  assign any_ev = i_tx_active | i_rx_active | i_rx_polarity_ok | i_jabber | i_collision;
  assign acc = i_psel & i_penable;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || any_ev) begin
      idle_cnt_r <= 32'h00000000;
    end else if (i_clk_en && idle_cnt_r < 32'h0000ffff) begin
      idle_cnt_r <= idle_cnt_r + 32'h00000001;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  property p_ready; o_pready == i_clk_en; endproperty
  a_ready: assert property (p_ready) else $error("pready differs from clock enable");
  property p_upper; acc && !i_pwrite |-> o_prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_resv; acc && !i_pwrite && i_paddr == 12'h000 |-> o_prdata[14:8] == 7'h00 && o_prdata[6:5] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_unmap; acc && i_paddr != 12'h000 && i_paddr != 12'h004 |-> o_pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on unmapped access");
  property p_mapped; acc && (i_paddr == 12'h000 || i_paddr == 12'h004) |-> !o_pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped access");
  property p_errdata; acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h00000000; endproperty
  a_errdata: assert property (p_errdata) else $error("failed read returns data");
  property p_live; i_psel && !i_penable && !i_pwrite && i_paddr == 12'h000 && !any_ev |=> !o_prdata[15]; endproperty
  a_live: assert property (p_live) else $error("live bit set without events");
  property p_cause; $fell(o_second_status_lamp_pin_b) |-> $past(any_ev, 2); endproperty
  a_cause: assert property (p_cause) else $error("lamp lit without event");
  property p_idle; idle_cnt_r > STRETCH_CYCLES + 4 |-> o_second_status_lamp_pin_b; endproperty
  a_idle: assert property (p_idle) else $error("lamp still lit after stretch");
endmodule

bind status_lamp_select lamp_sel_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_tx_active(i_tx_active), .i_rx_active(i_rx_active), .i_rx_polarity_ok(i_rx_polarity_ok),
  .i_jabber(i_jabber), .i_collision(i_collision), .o_second_status_lamp_pin_b(o_second_status_lamp_pin_b)
);

// File: tb/status_lamp_model.sv
`timescale 1ns/10ps
//****
// Lamp on the board
//****
module status_lamp_model (
  input  wire logic i_pin_b,
  output logic      o_lit
);
  assign o_lit = ~i_pin_b;
endmodule

// File: tb/status_lamp_select_tb_top.sv
`timescale 1ns/10ps
//****
// Bench
//****
module status_lamp_select_tb_top;
  localparam int STRETCH = 8;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  pstrb = 4'hf;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [4:0]  ev = 5'h00;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        rerr;
  logic        pin_b;
  logic        lit;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  status_lamp_select #(.STRETCH_CYCLES(STRETCH)) dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_tx_active(ev[4]), .i_rx_active(ev[2]),
    .i_rx_polarity_ok(ev[3]), .i_jabber(ev[1]), .i_collision(ev[0]), .o_second_status_lamp_pin_b(pin_b)
  );
  status_lamp_model lamp_dev (.i_pin_b(pin_b), .o_lit(lit));

  task automatic results;
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic lamp(input logic [4:0] e, input logic exp);
    ev <= e;
    repeat (3) @(posedge clk);
    check("lamp lit", 32'(lit), 32'(exp));
  endtask

  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h00000000);
    check("select reset", rdat, 32'h00000084);
    check("lamp idle", 32'(lit), 32'h00000000);
  endtask

  task automatic t_sources;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, 32'h00000001 << i);
      lamp(~(5'h01 << i), 1'b0);
      apb(1'b0, 12'h000, 32'h00000000);
      check("select live off", rdat, 32'h00000001 << i);
      lamp(5'h01 << i, 1'b1);
      apb(1'b0, 12'h000, 32'h00000000);
      check("select live on", rdat, 32'h00008000 | (32'h00000001 << i));
    end
  endtask

  task automatic t_combo;
    apb(1'b1, 12'h000, 32'h00000005);
    lamp(5'h04, 1'b1);
    lamp(5'h01, 1'b1);
    lamp(5'h1a, 1'b0);
  endtask

  task automatic t_reserved;
    ev <= 5'h00;
    apb(1'b1, 12'h000, 32'hffff809f);
    apb(1'b0, 12'h000, 32'h00000000);
    check("select reserved", rdat, 32'h0000009f);
  endtask

  task automatic t_unmapped;
    apb(1'b0, 12'h008, 32'h00000000);
    check("unmapped error", 32'(rerr), 32'h00000001);
    check("unmapped data", rdat, 32'h00000000);
  endtask

  task automatic t_stretch;
    apb(1'b1, 12'h000, 32'h00000084);
    lamp(5'h00, 1'b0);
    ev <= 5'h04;
    @(posedge clk);
    ev <= 5'h00;
    repeat (5) @(posedge clk);
    check("lamp stretched", 32'(lit), 32'h00000001);
    ev <= 5'h04;
    @(posedge clk);
    ev <= 5'h00;
    repeat (7) @(posedge clk);
    check("lamp restarted", 32'(lit), 32'h00000001);
    repeat (20) @(posedge clk);
    check("lamp expired", 32'(lit), 32'h00000000);
  endtask

  task automatic t_strobe;
    pstrb <= 4'he;
    apb(1'b1, 12'h000, 32'h00000001);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h00000000);
    check("select strobe off", rdat, 32'h00000084);
  endtask

  task automatic t_status;
    ev <= 5'h15;
    repeat (2) @(posedge clk);
    apb(1'b0, 12'h004, 32'h00000000);
    check("status read", rdat, 32'h00000115);
    apb(1'b1, 12'h004, 32'hffffffff);
    check("status write error", 32'(rerr), 32'h00000000);
    apb(1'b0, 12'h000, 32'h00000000);
    check("select live rx", rdat, 32'h00008084);
  endtask

  task automatic t_freeze;
    ev <= 5'h04;
    @(posedge clk);
    ev <= 5'h00;
    fork
      apb(1'b0, 12'h000, 32'h00000000);
      begin
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (20) @(posedge clk);
        check("ready frozen", 32'(pready), 32'h00000000);
        check("lamp frozen", 32'(lit), 32'h00000001);
        clk_en <= 1'b1;
      end
    join
    check("select after freeze", rdat, 32'h00000084);
    repeat (20) @(posedge clk);
    check("lamp after freeze", 32'(lit), 32'h00000000);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sources();
    t_combo();
    t_reserved();
    t_unmapped();
    t_stretch();
    t_strobe();
    t_status();
    t_freeze();
    results();
  end
endmodule
